// file: core/acq_trig_defs.svh
// Constants of the acquisition trigger controller: source indices,
// timing figures and sizes.
// Assumes a 40 MHz sample clock; included by bare name.
`ifndef ACQ_TRIG_DEFS_SVH
`define ACQ_TRIG_DEFS_SVH

// Clock rate in MHz
`define CLK_MHZ 40
// Sixteen channels, line reference, auxiliary input
`define CHAN_COUNT 16
`define SRC_COUNT 18
`define SRC_LINE 5'h10
`define SRC_AUX 5'h11
// Auto-mode timeout at the fastest time base, ns
`define AUTO_BASE_NS 200000
// Holdoff limits at the fastest time base, ns
`define HOLD_MIN_NS 1000
`define HOLD_MAX_NS 250000
// Full-scale holdoff percentage
`define PCT_FULL 7'h64
// Store depth and longest record
`define DEPTH_DEF 2048
`define REC_MAX 2000
// Duration counter width in engines
`define DUR_W 16

`endif

// file: core/acq_trig_pkg.sv
// Types shared by the trigger engines and the acquisition controller.
// Assumes acq_trig_defs.svh for widths.
`include "acq_trig_defs.svh"

package acq_trig_pkg;

   typedef enum logic [2:0] {
      TYPE_EDGE, TYPE_PULSE, TYPE_PATTERN, TYPE_STATE, TYPE_SEQUENCE
   } trig_kind_t;

   typedef enum logic [1:0] {
      QUAL_TRUE, QUAL_LESS, QUAL_MORE, QUAL_RANGE
   } qual_t;

   typedef enum logic [1:0] {
      ST_WAIT, ST_DELAY, ST_POST, ST_HOLD
   } acq_state_t;

   // One trigger system's settings
   typedef struct packed {
      trig_kind_t                kind;
      logic [4:0]                source;
      logic                      rising;
      logic                      glitch;
      logic                      positive;
      qual_t                     qual;
      logic [`DUR_W-1:0]         timeLo;
      logic [`DUR_W-1:0]         timeHi;
      logic                      anyOf;
      logic [`SRC_COUNT-1:0]     careA;
      logic [`SRC_COUNT-1:0]     levelA;
      logic [`SRC_COUNT-1:0]     careB;
      logic [`SRC_COUNT-1:0]     levelB;
      logic [4:0]                clkSource;
      logic                      clkRising;
   } trig_cfg_t;

endpackage

// file: core/trigger_engine.sv
// One trigger system: edge, pulse, pattern, state and sequence types.
// Assumes synchronised source levels on clk; hit is one cycle wide.
`timescale 1ns/1ps
`default_nettype none
`include "acq_trig_defs.svh"

module trigger_engine (
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire acq_trig_pkg::trig_cfg_t cfg,
   input  wire logic [`SRC_COUNT-1:0]  levels,
   output logic                        hit
);
   import acq_trig_pkg::*;

   logic                prevSrc, prevClk, prevCond, seqOn;
   logic [`DUR_W-1:0]   dur, seqCnt;
   logic                next_prevSrc, next_prevClk, next_prevCond, next_seqOn, next_hit;
   logic [`DUR_W-1:0]   next_dur, next_seqCnt;
   logic                src, clkLv, patA, patB, cond;

   // Time qualifier against a duration
   function automatic logic qualOk(input logic [`DUR_W-1:0] n, input trig_cfg_t c);
      unique case (c.qual)
         QUAL_TRUE:  qualOk = 1'b1;
         QUAL_LESS:  qualOk = n < c.timeLo;
         QUAL_MORE:  qualOk = n > c.timeLo;
         QUAL_RANGE: qualOk = (n >= c.timeLo) && (n <= c.timeHi);
      endcase
   endfunction

   // Boolean AND or OR of the cared source levels
   function automatic logic patOk(input logic [`SRC_COUNT-1:0] lv, input logic [`SRC_COUNT-1:0] care,
                                  input logic [`SRC_COUNT-1:0] want, input logic anyOf);
      patOk = anyOf ? |(~(lv ^ want) & care) : &(~((lv ^ want) & care));
   endfunction

   // Next state of the detectors
   always_comb begin
      src = levels[cfg.source];
      clkLv = levels[cfg.clkSource];
      patA = patOk(levels, cfg.careA, cfg.levelA, cfg.anyOf);
      patB = patOk(levels, cfg.careB, cfg.levelB, cfg.anyOf);
      cond = (cfg.kind == TYPE_PULSE) ? (src == cfg.positive) : patA;
      next_prevSrc = src;
      next_prevClk = clkLv;
      next_prevCond = cond;
      next_hit = 1'b0;
      next_seqOn = seqOn;
      next_seqCnt = seqCnt;
      // Length of the current or last true period
      if (cond && !prevCond)
         next_dur = `DUR_W'h1;
      else if (cond && !(&dur))
         next_dur = dur + `DUR_W'h1;
      else
         next_dur = dur;
      case (cfg.kind)
         TYPE_EDGE:
            next_hit = cfg.rising ? (src && !prevSrc) : (!src && prevSrc);
         TYPE_PULSE:
            next_hit = prevCond && !cond &&
                       (cfg.glitch ? (dur < cfg.timeLo) : (dur >= cfg.timeLo && dur <= cfg.timeHi));
         TYPE_PATTERN:
            next_hit = (cfg.qual == QUAL_TRUE) ? (cond && !prevCond) : (prevCond && !cond && qualOk(dur, cfg));
         TYPE_STATE:
            next_hit = patA && (cfg.clkRising ? (clkLv && !prevClk) : (!clkLv && prevClk));
         TYPE_SEQUENCE: begin
            if (!seqOn) begin
               next_seqOn = patA;
               next_seqCnt = `DUR_W'h0;
            end else if (patB) begin
               next_hit = qualOk(seqCnt, cfg);
               next_seqOn = 1'b0;
            end else if (&seqCnt) begin
               next_seqOn = 1'b0;
            end else begin
               next_seqCnt = seqCnt + `DUR_W'h1;
            end
         end
         default: next_hit = 1'b0;
      endcase
   end

   // Detector registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prevSrc <= 1'b0;
         prevClk <= 1'b0;
         prevCond <= 1'b0;
         seqOn <= 1'b0;
         dur <= `DUR_W'h0;
         seqCnt <= `DUR_W'h0;
         hit <= 1'b0;
      end else begin
         prevSrc <= next_prevSrc;
         prevClk <= next_prevClk;
         prevCond <= next_prevCond;
         seqOn <= next_seqOn;
         dur <= next_dur;
         seqCnt <= next_seqCnt;
         hit <= next_hit;
      end
   end

   edge_rise_a: assert property (@(posedge clk) disable iff (sys_rst)
      (cfg.kind == TYPE_EDGE && cfg.rising && src && !prevSrc) ##1 $stable(cfg) |-> hit)
      else $error("rising edge gave no hit");
   glitch_short_a: assert property (@(posedge clk) disable iff (sys_rst)
      (hit && cfg.kind == TYPE_PULSE && cfg.glitch && $stable(cfg)) |-> $past(dur) < cfg.timeLo)
      else $error("glitch hit on long pulse");
   state_true_a: assert property (@(posedge clk) disable iff (sys_rst)
      (hit && cfg.kind == TYPE_STATE && $stable(cfg)) |-> $past(patA))
      else $error("state hit with pattern false");
endmodule
`default_nettype wire

// file: core/acquisition_trigger_controller.sv
// Acquisition trigger controller: circular sample store, main and
// delayed trigger engines, normal and auto modes, force and holdoff.
// Assumes channel, line and aux inputs asynchronous; the rest on clk.
//
// Contract
// - keep pretrigger samples while waiting
// - ignore triggers until posttrigger complete
// - edge trigger on chosen crossing direction
// - sources are 16 channels, line, aux
// - source works regardless of display
// - pulse classes width and glitch
// - pattern true with time qualifier
// - state pattern sampled on clock edge
// - sequence start then end in time
// - normal mode waits for real trigger
// - force gives exactly one acquisition
// - auto timer forces trigger on timeout
// - auto timeout follows time base
// - holdoff after each acquisition
// - holdoff set 0 to 100 percent
// - main and delayed systems alike
`timescale 1ns/1ps
`default_nettype none
`include "acq_trig_defs.svh"

module acquisition_trigger_controller #(
   parameter int DEPTH     = `DEPTH_DEF,
   parameter int AUTO_BASE = `AUTO_BASE_NS * `CLK_MHZ / 1000,
   parameter int HOLD_MIN  = `HOLD_MIN_NS * `CLK_MHZ / 1000,
   parameter int HOLD_MAX  = `HOLD_MAX_NS * `CLK_MHZ / 1000,
   localparam int AW       = $clog2(DEPTH)
) (
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   input  wire logic [`CHAN_COUNT-1:0]  chanPin,
   input  wire logic                    linePin,
   input  wire logic                    auxPin,
   input  wire acq_trig_pkg::trig_cfg_t mainCfg,
   input  wire acq_trig_pkg::trig_cfg_t delayCfg,
   input  wire logic                    delayOn,
   input  wire logic                    autoMode,
   input  wire logic                    forceReq,
   input  wire logic [AW-1:0]           recordLen,
   input  wire logic [AW-1:0]           preCount,
   input  wire logic [3:0]              timeBase,
   input  wire logic [6:0]              holdoffPct,
   input  wire logic [AW-1:0]           rdAddr,
   output logic                         armed,
   output logic                         trigPulse,
   output logic                         forcedPulse,
   output logic                         doneFlag,
   output logic                         holdActive,
   output logic [AW-1:0]                trigAddr,
   output logic [`CHAN_COUNT-1:0]       rdData
);
   import acq_trig_pkg::*;

   // Refuse a store that cannot hold the longest record
   if (DEPTH != (1 << AW) || DEPTH < `REC_MAX) begin : g_bad_depth
      $error("DEPTH must be a power of two holding a full record");
   end
   if (HOLD_MAX < HOLD_MIN || AUTO_BASE < 1) begin : g_bad_time
      $error("timing parameters out of range");
   end

   logic [`SRC_COUNT-1:0]   pinS1, pinS2;
   logic                    mainHit, delayHit;
   logic [`CHAN_COUNT-1:0]  store [DEPTH];

   acq_state_t              state, next_state;
   logic [AW-1:0]           wrPtr, fillCnt, postCnt;
   logic [AW-1:0]           next_wrPtr, next_fillCnt, next_postCnt;
   logic [31:0]             holdCnt, autoCnt;
   logic [31:0]             next_holdCnt, next_autoCnt;
   logic                    forcePend, next_forcePend;
   logic                    next_armed, next_trigPulse, next_forcedPulse;
   logic                    next_doneFlag, next_holdActive;
   logic [AW-1:0]           next_trigAddr;

   logic [AW-1:0]           postLen;
   logic                    ready, autoFire, takeReal, takeForced;
   logic [31:0]             autoLimit, holdMin, holdMax, holdLen;
   logic [6:0]              pctC;

   // Two-stage synchroniser for pins
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pinS1 <= `SRC_COUNT'h0;
         pinS2 <= `SRC_COUNT'h0;
      end else begin
         pinS1 <= {auxPin, linePin, chanPin};
         pinS2 <= pinS1;
      end
   end

   trigger_engine mainEng (
      .clk     (clk),
      .sys_rst (sys_rst),
      .cfg     (mainCfg),
      .levels  (pinS2),
      .hit     (mainHit)
   );

   trigger_engine delayEng (
      .clk     (clk),
      .sys_rst (sys_rst),
      .cfg     (delayCfg),
      .levels  (pinS2),
      .hit     (delayHit)
   );

   // Timing limits from the time base
   always_comb begin
      autoLimit = 32'(AUTO_BASE) << timeBase;
      holdMin = 32'(HOLD_MIN) << timeBase;
      holdMax = 32'(HOLD_MAX) << timeBase;
      pctC = (holdoffPct > `PCT_FULL) ? `PCT_FULL : holdoffPct;
      holdLen = holdMin + 32'((40'(holdMax - holdMin) * 40'(pctC)) / 40'(`PCT_FULL));
   end

   // Sequencer next values
   always_comb begin
      postLen = recordLen - preCount;
      ready = fillCnt >= preCount;
      autoFire = autoMode && (autoCnt >= autoLimit - 32'h1);
      next_state = state;
      next_wrPtr = wrPtr + AW'(1);
      next_fillCnt = (&fillCnt) ? fillCnt : fillCnt + AW'(1);
      next_postCnt = postCnt;
      next_holdCnt = holdCnt;
      next_trigAddr = trigAddr;
      next_doneFlag = 1'b0;
      takeReal = 1'b0;
      takeForced = 1'b0;
      unique case (state)
         ST_WAIT: begin
            if (ready) begin
               if (mainHit && delayOn)
                  next_state = ST_DELAY;
               else if (mainHit)
                  takeReal = 1'b1;
               else if (forcePend || autoFire)
                  takeForced = 1'b1;
            end
         end
         // Delayed system gives the trigger point
         ST_DELAY: begin
            if (delayHit)
               takeReal = 1'b1;
            else if (forcePend)
               takeForced = 1'b1;
         end
         ST_POST: begin
            if ({1'b0, postCnt} + (AW + 1)'(1) >= {1'b0, postLen}) begin
               next_state = ST_HOLD;
               next_holdCnt = 32'h0;
               next_doneFlag = 1'b1;
            end else begin
               next_postCnt = postCnt + AW'(1);
            end
         end
         ST_HOLD: begin
            next_fillCnt = AW'(0);
            if (holdCnt >= holdLen)
               next_state = ST_WAIT;
            else
               next_holdCnt = holdCnt + 32'h1;
         end
      endcase
      if (takeReal || takeForced) begin
         next_state = ST_POST;
         next_postCnt = AW'(0);
         next_trigAddr = wrPtr;
      end
      if (mainHit || takeReal || takeForced)
         next_autoCnt = 32'h0;
      else if (state == ST_WAIT && autoMode && autoCnt != 32'hFFFFFFFF)
         next_autoCnt = autoCnt + 32'h1;
      else
         next_autoCnt = autoCnt;
      next_forcePend = forceReq || (forcePend && !takeForced && !takeReal);
      next_trigPulse = takeReal;
      next_forcedPulse = takeForced;
      next_armed = (next_state == ST_WAIT) || (next_state == ST_DELAY);
      next_holdActive = next_state == ST_HOLD;
   end

   // Sequencer registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= ST_HOLD;
         wrPtr <= AW'(0);
         fillCnt <= AW'(0);
         postCnt <= AW'(0);
         holdCnt <= 32'h0;
         autoCnt <= 32'h0;
         forcePend <= 1'b0;
         trigAddr <= AW'(0);
         armed <= 1'b0;
         trigPulse <= 1'b0;
         forcedPulse <= 1'b0;
         doneFlag <= 1'b0;
         holdActive <= 1'b1;
      end else begin
         state <= next_state;
         wrPtr <= next_wrPtr;
         fillCnt <= next_fillCnt;
         postCnt <= next_postCnt;
         holdCnt <= next_holdCnt;
         autoCnt <= next_autoCnt;
         forcePend <= next_forcePend;
         trigAddr <= next_trigAddr;
         armed <= next_armed;
         trigPulse <= next_trigPulse;
         forcedPulse <= next_forcedPulse;
         doneFlag <= next_doneFlag;
         holdActive <= next_holdActive;
      end
   end

   always_ff @(posedge clk) begin
      store[wrPtr] <= pinS2[`CHAN_COUNT-1:0];
      rdData <= sys_rst ? `CHAN_COUNT'h0 : store[rdAddr];
   end

   // Done pulse lands together with the holdoff flag, then drops
   sequence done_s;
      (doneFlag && holdActive && !armed) ##1 !doneFlag;
   endsequence

   pre_fill_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state == ST_WAIT && (takeReal || takeForced)) |-> fillCnt >= preCount)
      else $error("trigger taken before pretrigger filled");
   post_ignore_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state == ST_POST) |=> !trigPulse && !forcedPulse)
      else $error("trigger accepted during posttrigger");
   normal_stay_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state == ST_WAIT && !autoMode && !mainHit && !forcePend) |=> state == ST_WAIT)
      else $error("normal mode left waiting without event");
   force_take_a: assert property (@(posedge clk) disable iff (sys_rst)
      (forcePend && state == ST_WAIT && ready && !mainHit) |=> forcedPulse ##1 !forcedPulse)
      else $error("force did not give one acquisition");
   auto_fire_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state == ST_WAIT && ready && autoMode && autoCnt >= autoLimit - 32'h1 && !mainHit) |=> forcedPulse)
      else $error("auto timeout gave no forced trigger");
   hold_enter_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state == ST_POST && next_doneFlag) |=> done_s)
      else $error("acquisition end did not start holdoff");
   hold_stay_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state == ST_HOLD && holdCnt < holdLen && $stable(holdLen)) |=> state == ST_HOLD && !armed)
      else $error("holdoff ended early");
   hold_map_a: assert property (@(posedge clk) disable iff (sys_rst)
      holdLen >= holdMin && holdLen <= holdMax)
      else $error("holdoff outside limits");
endmodule
`default_nettype wire

// file: sim/acquisition_trigger_controller_test.sv
// Self-checking bench of the acquisition trigger controller: edge and pattern
// sources, post-trigger length, holdoff length, force and auto timeout.
// Assumes the design with shortened timing parameters and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "acq_trig_defs.svh"

module acquisition_trigger_controller_test;
   import acq_trig_pkg::*;

   localparam int AB   = 20;
   localparam int HMN  = 2;
   localparam int HMX  = 30;
   localparam int RLEN = 40;
   localparam int PRE  = 4;
   localparam int LIM  = 5000;

   typedef struct {
      trig_kind_t kind;
      logic [4:0] src;
      logic       rising;
      logic [3:0] tb;
      logic [6:0] pct;
   } row_t;

   logic                clk = 1'b0;
   logic                sys_rst = 1'b1;
   logic [17:0]         pins = '0;
   trig_cfg_t           mainCfg = '0;
   trig_cfg_t           delayCfg = '0;
   logic                delayOn = 1'b0;
   logic [10:0]         rdAddr = '0;
   logic                autoMode = 1'b0;
   logic                forceReq = 1'b0;
   logic [3:0]          timeBase = '0;
   logic [6:0]          holdoffPct = '0;
   logic                armed, trigPulse, forcedPulse, doneFlag, holdActive;
   logic [10:0]         trigAddr;
   logic [15:0]         rdData;
   int                  error_cnt = 0;
   int                  compares = 0;
   int                  wc, nt, nf, pc, hc;
   row_t                rows [5];

   // Half-period toggle, 25 ns period
   always #12.5 clk = ~clk;

   acquisition_trigger_controller #(.AUTO_BASE(AB), .HOLD_MIN(HMN), .HOLD_MAX(HMX)) i_acquisition_trigger_controller (
      .clk(clk), .sys_rst(sys_rst), .chanPin(pins[15:0]), .linePin(pins[16]), .auxPin(pins[17]),
      .mainCfg(mainCfg), .delayCfg(delayCfg), .delayOn(delayOn), .autoMode(autoMode), .forceReq(forceReq),
      .recordLen(11'(RLEN)), .preCount(11'(PRE)), .timeBase(timeBase), .holdoffPct(holdoffPct),
      .rdAddr(rdAddr), .armed(armed), .trigPulse(trigPulse), .forcedPulse(forcedPulse),
      .doneFlag(doneFlag), .holdActive(holdActive), .trigAddr(trigAddr), .rdData(rdData));

   // Verdict and end of run
   task automatic complete_run();
      if (error_cnt == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // One comparison, mismatch printed at once
   task automatic check(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask

   // Bounded-wait exhaustion ends the run
   task automatic hang(input string msg);
      check(1'b0, msg);
      complete_run();
   endtask

   // Expected holdoff count for a time base and percentage
   function automatic int holdExp(input int tb, input int pct);
      int mn;
      int mx;
      int p;
      mn = HMN << tb;
      mx = HMX << tb;
      p  = (pct > 100) ? 100 : pct;
      return mn + (mx - mn) * p / 100 + 1;
   endfunction

   // One acquisition: wait for acceptance, re-toggle source in post, time post and holdoff
   task automatic run_acq(input int src, input int tb, input int pct);
      int i;
      wc = 0;
      nt = 0;
      nf = 0;
      for (i = 0; i < LIM; i++) begin
         @(negedge clk);
         if (trigPulse === 1'b1 || forcedPulse === 1'b1) break;
         wc++;
      end
      if (i == LIM) hang("no acceptance");
      nt = int'(trigPulse === 1'b1);
      nf = int'(forcedPulse === 1'b1);
      check(armed === 1'b0, "armed during post");
      pc = 0;
      for (i = 0; i < LIM; i++) begin
         @(negedge clk);
         pc++;
         if (trigPulse === 1'b1 || forcedPulse === 1'b1) check(1'b0, "second trigger in post");
         if (pc == 8 || pc == 12) pins[src] = ~pins[src];
         if (doneFlag === 1'b1) break;
      end
      if (i == LIM) hang("no done");
      check(pc == RLEN - PRE, "post length");
      // Holdoff flag rises with the done pulse; that cycle counts
      check(holdActive === 1'b1, "holdoff not started with done");
      hc = 1;
      for (i = 0; i < LIM; i++) begin
         @(negedge clk);
         if (holdActive !== 1'b1) break;
         check(armed === 1'b0 && trigPulse === 1'b0, "trigger during holdoff");
         hc++;
      end
      if (i == LIM) hang("holdoff stuck");
      check(hc == holdExp(tb, pct), "holdoff length");
      check(armed === 1'b1, "not rearmed after holdoff");
   endtask

   // No acceptance for n cycles while armed
   task automatic quiet(input int n);
      repeat (n) begin
         @(negedge clk);
         check(trigPulse === 1'b0 && forcedPulse === 1'b0 && armed === 1'b1, "unexpected acquisition");
      end
   endtask

   initial begin
      // Ordinary cases: kind, source, direction, time base, holdoff percent
      rows[0] = '{TYPE_EDGE, 5'h00, 1'b1, 4'h0, 7'h00};
      rows[1] = '{TYPE_EDGE, 5'h0F, 1'b0, 4'h1, 7'h32};
      rows[2] = '{TYPE_EDGE, `SRC_LINE, 1'b1, 4'h0, 7'h64};
      rows[3] = '{TYPE_EDGE, `SRC_AUX, 1'b0, 4'h2, 7'h19};
      rows[4] = '{TYPE_PATTERN, 5'h07, 1'b1, 4'h0, 7'h78};
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
      @(negedge clk);
      check(armed === 1'b0 && holdActive === 1'b1 && trigPulse === 1'b0, "reset state");
      check(trigAddr === 11'h000, "reset trigger address");
      // Row loop: arm, make the edge, check one real trigger
      foreach (rows[r]) begin
         mainCfg = '0;
         mainCfg.kind = rows[r].kind;
         mainCfg.source = rows[r].src;
         mainCfg.rising = rows[r].rising;
         mainCfg.qual = QUAL_TRUE;
         mainCfg.careA[rows[r].src] = 1'b1;
         mainCfg.levelA[rows[r].src] = 1'b1;
         timeBase = rows[r].tb;
         holdoffPct = rows[r].pct;
         pins[rows[r].src] = ~rows[r].rising;
         for (int i = 0; i <= LIM && armed !== 1'b1; i++) begin
            @(negedge clk);
            if (i == LIM) hang("never armed");
         end
         repeat (6) @(negedge clk);
         pins[rows[r].src] = rows[r].rising;
         run_acq(rows[r].src, rows[r].tb, rows[r].pct);
         check(nt == 1 && nf == 0 && wc <= 6, "edge not taken as trigger");
         // Stored samples around the trigger point
         if (rows[r].src < 5'h10) begin
            rdAddr = trigAddr - 11'h2;
            @(negedge clk);
            check(rdData[rows[r].src[3:0]] === ~rows[r].rising, "sample before edge");
            rdAddr = trigAddr - 11'h1;
            @(negedge clk);
            check(rdData[rows[r].src[3:0]] === rows[r].rising, "sample after edge");
         end
      end
      // Wrong direction in normal mode stays armed
      mainCfg = '0;
      mainCfg.kind = TYPE_EDGE;
      mainCfg.rising = 1'b1;
      timeBase = 4'h0;
      holdoffPct = 7'h00;
      pins[0] = 1'b1;
      quiet(10);
      pins[0] = 1'b0;
      quiet(100);
      // Force with no event: exactly one acquisition
      forceReq = 1'b1;
      @(negedge clk);
      forceReq = 1'b0;
      run_acq(0, 0, 0);
      check(nf == 1 && nt == 0, "force acquisition");
      quiet(100);
      // Auto timeout at two time bases
      autoMode = 1'b1;
      for (int tb = 0; tb < 2; tb++) begin
         timeBase = 4'(tb);
         run_acq(0, tb, 0);
         run_acq(0, tb, 0);
         check(nf == 1 && nt == 0, "auto forced trigger");
         check(wc >= (AB << tb) - 3 && wc <= (AB << tb) + 3, "auto timeout length");
      end
      autoMode = 1'b0;
      // Delayed system gives the trigger point after a main event
      timeBase = 4'h0;
      delayCfg = '0;
      delayCfg.kind = TYPE_EDGE;
      delayCfg.source = 5'h01;
      delayCfg.rising = 1'b1;
      delayOn = 1'b1;
      quiet(10);
      pins[0] = 1'b1;
      quiet(20);
      pins[1] = 1'b1;
      run_acq(1, 0, 0);
      check(nt == 1 && nf == 0 && wc <= 6, "delayed trigger not taken");
      delayOn = 1'b0;
      // Reset in mid-run: outputs cleared but holdActive set, then a force still works
      sys_rst = 1'b1;
      repeat (3) @(negedge clk);
      check(armed === 1'b0 && holdActive === 1'b1 && trigAddr === 11'h000 && rdData === 16'h0000,
            "mid-run reset state");
      sys_rst = 1'b0;
      @(negedge clk);
      check(armed === 1'b0 && holdActive === 1'b1 && forcedPulse === 1'b0, "state after mid-run reset");
      forceReq = 1'b1;
      @(negedge clk);
      forceReq = 1'b0;
      run_acq(0, 0, 0);
      check(nf == 1 && nt == 0, "force after reset");
      complete_run();
   end

endmodule
`default_nettype wire
